// [pkg/tx_framing_defines.svh]
// Register map, field positions and timing constants of the transmit framing block
`ifndef TX_FRAMING_DEFINES_SVH
`define TX_FRAMING_DEFINES_SVH
`define ADDR_PULSE_WIDTH 8'h2F
`define ADDR_BURST_LEN 8'h30
`define ADDR_WAIT_CTRL 8'h31
`define ADDR_WAIT_LOW 8'h32
`define ADDR_FRAME_CFG 8'h33
`define ADDR_STATUS 8'h3F
`define WAIT_CTRL_RESET 8'hC0
`define REG_ZERO_RESET 8'h00
`define BURST_WRITE_MASK 8'h77
`define FRAME_WRITE_MASK 8'hCF
`define WAIT_START_BIT 7
`define WAIT_UNIT_BIT 6
`define WAIT_HIGH_MSB 5
`define WAIT_HIGH_LSB 3
`define STOP_GUARD_MSB 2
`define STOP_GUARD_LSB 0
`define SYM1_BURST_MSB 6
`define SYM1_BURST_LSB 4
`define SYM0_BURST_MSB 2
`define SYM0_BURST_LSB 0
`define TX_PARITY_BIT 7
`define RX_PARITY_BIT 6
`define STOP_SYM_MSB 3
`define STOP_SYM_LSB 2
`define START_SYM_MSB 1
`define START_SYM_LSB 0
`define CLOCK_KHZ 125000
`define CARRIER_KHZ 13560
`define WAIT_UNIT_CARRIERS 8'h10
`define SLOT_CARRIERS_MAX 8'h80
`endif

// [pkg/tx_framing_pkg.sv]
// Types shared by the transmit framing block
package tx_framing_pkg;
  // Frame sequencer, Gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HOLD = 3'b001,
    ST_SSYM = 3'b011,
    ST_BYTE = 3'b010,
    ST_GUARD = 3'b110,
    ST_ESYM = 3'b111
  } state_e;
  // Software visible registers
  typedef struct packed {
    logic [7:0] width;
    logic [7:0] burst;
    logic [7:0] wctrl;
    logic [7:0] wlow;
    logic [7:0] frame;
  } regs_s;
  // Whole state of the block
  typedef struct packed {
    regs_s regs;
    state_e st;
    logic [16:0] acc;
    logic tick;
    logic [7:0] slot_c;
    logic [8:0] slots;
    logic [8:0] pulse_cnt;
    logic [3:0] bit_idx;
    logic [7:0] shreg;
    logic par;
    logic have;
    logic last;
    logic [1:0] sym;
    logic burst;
    logic cur_bit;
    logic [10:0] wait_cnt;
    logic [7:0] unit_c;
    logic pending;
    logic tx_end;
    logic [7:0] rdata;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_perr;
  } state_s;
endpackage

// [design/nfc_tx_framing_control.sv]
// Transmit framing, pulse, burst and wait control of the reader front end
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "tx_framing_defines.svh"
module nfc_tx_framing_control #(
  parameter int unsigned CLOCK_KHZ = `CLOCK_KHZ
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [7:0] o_rdata,
  input wire logic [1:0] i_rate_sel,
  input wire logic i_miller_en,
  input wire logic i_pulse_start_select,
  input wire logic i_burst_en,
  input wire logic [1:0] i_burst_level_control,
  input wire logic i_type_b,
  input wire logic i_tx_start,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_last,
  output logic o_tx_ready,
  input wire logic i_rx_end,
  input wire logic i_rx_valid,
  input wire logic [8:0] i_rx_data,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_parity_error,
  output logic o_tx_bit,
  output logic o_mod_pulse,
  output logic o_burst_active,
  output logic o_busy,
  output logic o_tx_end
);
  import tx_framing_pkg::*;

  // **********************************
  // Parameter checks
  // **********************************
  // Divider needs a clock faster than the carrier and a 17-bit phase
  if (CLOCK_KHZ <= `CARRIER_KHZ || CLOCK_KHZ > 131071) begin : g_bad_clock
    $error("clock rate unusable for carrier divider");
  end

  // **********************************
  // Helpers
  // **********************************
  // Burst code to bit count
  function automatic logic [8:0] burst_bits(input logic [2:0] code);
    logic [8:0] b;
    case (code)
      3'h0: b = 9'h008;
      3'h1: b = 9'h010;
      3'h2: b = 9'h020;
      3'h3: b = 9'h030;
      3'h4: b = 9'h040;
      3'h5: b = 9'h060;
      3'h6: b = 9'h080;
      default: b = 9'h100;
    endcase
    return b;
  endfunction

  // Register index, 0 for unmapped; used by read and write
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    logic [2:0] r;
    r = 3'h0;
    if (a == `ADDR_PULSE_WIDTH) r = 3'h1;
    else if (a == `ADDR_BURST_LEN) r = 3'h2;
    else if (a == `ADDR_WAIT_CTRL) r = 3'h3;
    else if (a == `ADDR_WAIT_LOW) r = 3'h4;
    else if (a == `ADDR_FRAME_CFG) r = 3'h5;
    else if (a == `ADDR_STATUS) r = 3'h6;
    return r;
  endfunction

  state_s s_r;
  state_s s_nxt;
  logic [7:0] slot_len;
  logic [7:0] half_len;
  logic [7:0] unit_len;
  logic [7:0] start_pos;
  logic [10:0] wait_value;
  logic active;
  logic slot_end;
  logic needs_pulse;
  logic tx_par_en;
  logic rx_par_en;

  // **********************************
  // Derived timing
  // **********************************
  // Bit slot shrinks with rate: 128, 64, 32, 16 carriers
  assign slot_len = `SLOT_CARRIERS_MAX >> i_rate_sel;
  assign half_len = slot_len >> 1;
  assign unit_len = s_r.regs.wctrl[`WAIT_UNIT_BIT] ? half_len : `WAIT_UNIT_CARRIERS;
  assign wait_value = {s_r.regs.wctrl[`WAIT_HIGH_MSB:`WAIT_HIGH_LSB], s_r.regs.wlow};
  assign tx_par_en = s_r.regs.frame[`TX_PARITY_BIT];
  assign rx_par_en = s_r.regs.frame[`RX_PARITY_BIT];
  assign active = (s_r.st == ST_SSYM) || (s_r.st == ST_ESYM) || (s_r.st == ST_GUARD) ||
                  (s_r.st == ST_BYTE && s_r.have);
  assign slot_end = active && s_r.tick && (s_r.slot_c == slot_len - 8'h01);
  // pulses only under Miller and outside bursts; symbols 2 and 3 included, symbol 1 never
  assign needs_pulse = i_miller_en && !s_r.burst && (s_r.cur_bit || s_r.sym == 2'h3);
  // start position; symbol 3 always pulses at bit start
  assign start_pos = (i_pulse_start_select && s_r.sym != 2'h3) ? half_len : 8'h00;

  // **********************************
  // Next state
  // **********************************
  // One pass over sequencer, timers, wait gate and registers
  always_comb begin
    logic [17:0] acc_sum; // Spare bit: phase plus step can pass 2^17 at fast clocks
    logic to_end;
    logic finish;
    logic [1:0] esym;
    acc_sum = 18'h00000;
    to_end = 1'b0;
    finish = 1'b0;
    esym = s_r.regs.frame[`STOP_SYM_MSB:`STOP_SYM_LSB];
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    s_nxt.tx_end = 1'b0;
    s_nxt.rx_valid = 1'b0;

    // Fractional divider makes the carrier enable pulse
    acc_sum = {1'b0, s_r.acc} + 18'(`CARRIER_KHZ);
    if (acc_sum >= 18'(CLOCK_KHZ)) begin
      s_nxt.acc = 17'(acc_sum - 18'(CLOCK_KHZ));
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.acc = acc_sum[16:0];
    end

    // Slot carrier counter
    if (active && s_r.tick) begin
      s_nxt.slot_c = slot_end ? 8'h00 : s_r.slot_c + 8'h01;
    end

    if (active && s_r.tick && s_r.slot_c == start_pos && needs_pulse) begin
      s_nxt.pulse_cnt = {1'b0, s_r.regs.width} + 9'h001;
    end else if (s_r.tick && s_r.pulse_cnt != 9'h000) begin
      s_nxt.pulse_cnt = s_r.pulse_cnt - 9'h001;
    end
    if (slot_end || !active) begin
      s_nxt.pulse_cnt = 9'h000;
    end

    // Request stays pending until the sequencer accepts it
    if (i_tx_start) begin
      s_nxt.pending = 1'b1;
    end

    case (s_r.st)
      ST_IDLE: begin
        if (s_nxt.pending) begin
          s_nxt.pending = 1'b0;
          s_nxt.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // hold until the wait has run out
        if (s_r.wait_cnt == 11'h000) begin
          s_nxt.slot_c = 8'h00;
          s_nxt.sym = s_r.regs.frame[`START_SYM_MSB:`START_SYM_LSB];
          if (s_nxt.sym != 2'h0) begin
            s_nxt.st = ST_SSYM;
          end else begin
            s_nxt.st = ST_BYTE;
            s_nxt.have = 1'b0;
          end
        end
      end
      ST_SSYM, ST_ESYM: begin
        if (slot_end) begin
          s_nxt.slots = s_r.slots - 9'h001;
          if (s_r.slots == 9'h001) begin
            s_nxt.burst = 1'b0;
            s_nxt.sym = 2'h0;
            if (s_r.st == ST_ESYM) begin
              finish = 1'b1;
            end else begin
              s_nxt.st = ST_BYTE;
              s_nxt.have = 1'b0;
            end
          end
        end
      end
      ST_BYTE: begin
        if (!s_r.have) begin
          // Byte taken only between bytes; stalls the slot timer meanwhile
          if (i_tx_valid) begin
            s_nxt.have = 1'b1;
            s_nxt.shreg = i_tx_data;
            s_nxt.cur_bit = i_tx_data[0];
            s_nxt.par = ~^i_tx_data;
            s_nxt.last = i_tx_last;
            s_nxt.bit_idx = 4'h0;
            s_nxt.slot_c = 8'h00;
          end
        end else if (slot_end) begin
          if (s_r.bit_idx < 4'h7) begin
            s_nxt.bit_idx = s_r.bit_idx + 4'h1;
            s_nxt.shreg = s_r.shreg >> 1;
            s_nxt.cur_bit = s_r.shreg[1];
          end else if (s_r.bit_idx == 4'h7 && tx_par_en) begin
            // odd parity bit after the byte
            s_nxt.bit_idx = 4'h8;
            s_nxt.cur_bit = s_r.par;
          end else begin
            s_nxt.have = 1'b0;
            if (s_r.last) begin
              // stop bit and extra guard units, type B only
              if (i_type_b && s_r.regs.wctrl[`STOP_GUARD_MSB:`STOP_GUARD_LSB] != 3'h0) begin
                s_nxt.st = ST_GUARD;
                s_nxt.slots = {6'h00, s_r.regs.wctrl[`STOP_GUARD_MSB:`STOP_GUARD_LSB]};
                s_nxt.cur_bit = 1'b1;
              end else begin
                to_end = 1'b1;
              end
            end
          end
        end
      end
      ST_GUARD: begin
        if (slot_end) begin
          s_nxt.slots = s_r.slots - 9'h001;
          if (s_r.slots == 9'h001) begin
            to_end = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    if (to_end) begin
      if (esym != 2'h0) begin
        s_nxt.st = ST_ESYM;
        s_nxt.sym = esym;
        s_nxt.slot_c = 8'h00;
      end else begin
        finish = 1'b1;
      end
    end

    // symbol 0 and 1 as bursts at the chosen level
    if ((s_nxt.st == ST_SSYM || s_nxt.st == ST_ESYM) && s_nxt.st != s_r.st) begin
      s_nxt.burst = i_burst_en && s_nxt.sym != 2'h3;
      s_nxt.cur_bit = (s_nxt.sym == 2'h1) ? 1'b0 : 1'b1;
      s_nxt.slots = 9'h001;
      if (s_nxt.burst) begin
        s_nxt.cur_bit = i_burst_level_control[s_nxt.sym[1]];
        s_nxt.slots = s_nxt.sym[1] ?
          burst_bits(s_r.regs.burst[`SYM1_BURST_MSB:`SYM1_BURST_LSB]) :
          burst_bits(s_r.regs.burst[`SYM0_BURST_MSB:`SYM0_BURST_LSB]);
      end
    end

    if (finish) begin
      s_nxt.st = ST_IDLE;
      s_nxt.tx_end = 1'b1;
      s_nxt.cur_bit = 1'b0;
    end

    // minimum gap enforced by the counter
    if ((finish && !s_r.regs.wctrl[`WAIT_START_BIT]) ||
        (i_rx_end && s_r.regs.wctrl[`WAIT_START_BIT])) begin
      s_nxt.wait_cnt = wait_value;
      s_nxt.unit_c = 8'h00;
    end else if (s_r.wait_cnt != 11'h000 && s_r.tick) begin
      if (s_r.unit_c >= unit_len - 8'h01) begin
        s_nxt.unit_c = 8'h00;
        s_nxt.wait_cnt = s_r.wait_cnt - 11'h001;
      end else begin
        s_nxt.unit_c = s_r.unit_c + 8'h01;
      end
    end

    if (i_rx_valid) begin
      s_nxt.rx_valid = 1'b1;
      s_nxt.rx_data = i_rx_data[7:0];
      s_nxt.rx_perr = rx_par_en && !(^i_rx_data);
    end

    // Register writes; reserved bits kept at zero
    if (i_write) begin
      case (reg_sel(i_addr))
        3'h1: s_nxt.regs.width = i_wdata;
        3'h2: s_nxt.regs.burst = i_wdata & `BURST_WRITE_MASK;
        3'h3: s_nxt.regs.wctrl = i_wdata;
        3'h4: s_nxt.regs.wlow = i_wdata;
        3'h5: s_nxt.regs.frame = i_wdata & `FRAME_WRITE_MASK;
        default: s_nxt.regs = s_r.regs;
      endcase
    end

    // Read data for the next cycle; unmapped reads zero
    s_nxt.rdata = 8'h00;
    if (i_read) begin
      case (reg_sel(i_addr))
        3'h1: s_nxt.rdata = s_r.regs.width;
        3'h2: s_nxt.rdata = s_r.regs.burst;
        3'h3: s_nxt.rdata = s_r.regs.wctrl;
        3'h4: s_nxt.rdata = s_r.regs.wlow;
        3'h5: s_nxt.rdata = s_r.regs.frame;
        3'h6: s_nxt.rdata = {4'h0, s_r.rx_perr, s_r.pending, s_r.wait_cnt != 11'h000, s_r.st != ST_IDLE};
        default: s_nxt.rdata = 8'h00;
      endcase
    end
  end

  // **********************************
  // State register
  // **********************************
  // wait control comes up at C0h
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.regs.wctrl <= `WAIT_CTRL_RESET;
      s_r.regs.width <= `REG_ZERO_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from state
  assign o_rdata = s_r.rdata;
  assign o_tx_ready = (s_r.st == ST_BYTE) && !s_r.have;
  assign o_rx_valid = s_r.rx_valid;
  assign o_rx_data = s_r.rx_data;
  assign o_rx_parity_error = s_r.rx_perr;
  assign o_tx_bit = s_r.cur_bit;
  assign o_mod_pulse = s_r.pulse_cnt != 9'h000;
  assign o_burst_active = s_r.burst;
  assign o_busy = s_r.st != ST_IDLE;
  assign o_tx_end = s_r.tx_end;

  // **********************************
  // Assertions
  // **********************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sequence s_wait_armed;
    o_tx_end && !s_r.regs.wctrl[`WAIT_START_BIT];
  endsequence
  sequence s_last_data_bit;
    s_r.st == ST_BYTE && s_r.bit_idx == 4'h7 && slot_end && tx_par_en;
  endsequence
  sequence s_guard_entry;
    s_r.st != ST_GUARD ##1 s_r.st == ST_GUARD;
  endsequence

  pulse_width_a: assert property (
    $rose(o_mod_pulse) |-> s_r.pulse_cnt == {1'b0, $past(s_r.regs.width)} + 9'h001)
    else $error("pulse width not width plus one");
  pulse_cut_a: assert property (
    slot_end |=> !o_mod_pulse) else $error("pulse crossed bit boundary");
  burst_len_a: assert property (
    $rose(o_burst_active) |-> s_r.slots == (s_r.sym[1] ?
      burst_bits($past(s_r.regs.burst[`SYM1_BURST_MSB:`SYM1_BURST_LSB])) :
      burst_bits($past(s_r.regs.burst[`SYM0_BURST_MSB:`SYM0_BURST_LSB]))))
    else $error("burst length wrong");
  wait_load_a: assert property (
    s_wait_armed |-> s_r.wait_cnt == $past(wait_value)) else $error("wait not loaded");
  wait_hold_a: assert property (
    (s_r.st == ST_HOLD && s_r.wait_cnt != 11'h000) |=> s_r.st == ST_HOLD)
    else $error("transmit left hold early");
  reset_value_a: assert property (
    $past(i_reset) |-> s_r.regs.wctrl == `WAIT_CTRL_RESET) else $error("wait control reset wrong");
  tx_parity_a: assert property (
    s_last_data_bit |=> s_r.bit_idx == 4'h8 && o_tx_bit == s_r.par) else $error("parity bit missing");
  rx_parity_a: assert property (
    i_rx_valid |=> o_rx_valid && o_rx_data == $past(i_rx_data[7:0]) &&
      o_rx_parity_error == ($past(rx_par_en) && !$past(^i_rx_data)))
    else $error("receive parity handling wrong");
  guard_len_a: assert property (
    s_guard_entry |-> s_r.slots == {6'h00, $past(s_r.regs.wctrl[`STOP_GUARD_MSB:`STOP_GUARD_LSB])})
    else $error("guard length wrong");
endmodule
`default_nettype wire

// [sim/rf_card_model.sv]
// Behavioural card that answers the reader across the RF field
`timescale 1ns/100ps
`default_nettype none
module rf_card_model (
  input wire logic i_clock,
  output logic o_rx_end,
  output logic o_rx_valid,
  output logic [8:0] o_rx_data
);
  // Idle pattern, never a stale byte
  initial begin
    o_rx_end = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_data = 9'h155;
  end
  // ************************************
  // One received byte, then end of data
  // ************************************
  // Gap of at least one cycle keeps changes just after an edge
  task automatic reply(input int gap, input logic [7:0] d, input logic bad);
    repeat (gap) @(posedge i_clock);
    o_rx_valid <= 1'b1;
    o_rx_data <= {(~^d) ^ bad, d};
    @(posedge i_clock);
    o_rx_valid <= 1'b0;
    // Released data shows the inverse so stale values never match
    o_rx_data <= ~{(~^d) ^ bad, d};
    o_rx_end <= 1'b1;
    @(posedge i_clock);
    o_rx_end <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [sim/nfc_tx_framing_control_tb_top.sv]
// Self-checking bench of the transmit framing block
`timescale 1ns/100ps
`default_nettype none
module nfc_tx_framing_control_tb_top;
  // Exact carrier tick every two clocks keeps slot timing integral
  localparam int CLK_KHZ = 27120;
  logic i_clock, i_reset, i_write, i_read, i_miller_en, i_pulse_start_select, i_burst_en, i_type_b;
  logic i_tx_start, i_tx_valid, i_tx_last, i_rx_end, i_rx_valid;
  logic [7:0] i_addr, i_wdata, i_tx_data, o_rdata, o_rx_data;
  logic [1:0] i_rate_sel, i_burst_level_control;
  logic [8:0] i_rx_data;
  logic o_tx_ready, o_rx_valid, o_rx_parity_error, o_tx_bit, o_mod_pulse, o_burst_active, o_busy, o_tx_end;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic q[$];
  int len, bcyc, blvl, prun;

  nfc_tx_framing_control #(.CLOCK_KHZ(CLK_KHZ)) dut (
    .i_clock, .i_reset, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata, .i_rate_sel, .i_miller_en,
    .i_pulse_start_select, .i_burst_en, .i_burst_level_control, .i_type_b, .i_tx_start, .i_tx_valid,
    .i_tx_data, .i_tx_last, .o_tx_ready, .i_rx_end, .i_rx_valid, .i_rx_data, .o_rx_valid, .o_rx_data,
    .o_rx_parity_error, .o_tx_bit, .o_mod_pulse, .o_burst_active, .o_busy, .o_tx_end
  );
  rf_card_model card (.i_clock, .o_rx_end(i_rx_end), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data));

  // 125 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  // ************************************
  // Shared helpers
  // ************************************
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  function automatic logic near(input int a, input int b, input int tol);
    return (a - b <= tol) && (b - a <= tol);
  endfunction
  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Trailing edge keeps back-to-back strobes apart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    @(posedge i_clock);
    chk(o_rdata === e, "register read");
  endtask
  // One-byte frame; records slot bits, burst and pulse timing
  task automatic run_frame(input logic [7:0] d);
    logic got;
    int run;
    got = 1'b0;
    run = 0;
    len = 0;
    bcyc = 0;
    blvl = 0;
    prun = 0;
    q.delete();
    i_tx_data <= d;
    i_tx_start <= 1'b1;
    @(posedge i_clock);
    i_tx_start <= 1'b0;
    while (o_tx_end !== 1'b1 && len < 30000) begin
      @(posedge i_clock);
      len++;
      if (len == 1) chk(o_busy === 1'b1, "not busy while held"); // request held
      if (got) q.push_back(o_tx_bit);
      bcyc += (o_burst_active === 1'b1);
      blvl += (o_burst_active === 1'b1 && o_tx_bit === 1'b1);
      run = (o_mod_pulse === 1'b1) ? run + 1 : 0;
      if (run > prun) prun = run;
      if (i_tx_valid && o_tx_ready === 1'b1) begin
        i_tx_valid <= 1'b0;
        got = 1'b1;
      end else if (!got && o_tx_ready === 1'b1) i_tx_valid <= 1'b1;
    end
    chk(o_tx_end === 1'b1 && o_busy === 1'b0, "frame did not end"); // sequencer idle again
  endtask
  // ************************************
  // Scenarios
  // ************************************
  task automatic t_regs();
    rd(8'h2F, 8'h00);
    rd(8'h30, 8'h00);
    rd(8'h31, 8'hC0); // wait control reset
    rd(8'h32, 8'h00);
    rd(8'h33, 8'h00);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h77);
    wr(8'h33, 8'hFF);
    rd(8'h33, 8'hCF);
    wr(8'h3F, 8'hFF);
    rd(8'h3F, 8'h00);
    wr(8'h40, 8'hA5);
    rd(8'h40, 8'h00);
    wr(8'h2F, 8'h5A);
    rd(8'h2F, 8'h5A);
  endtask
  task automatic t_tx_parity();
    logic [7:0] d;
    d = 8'hA5;
    wr(8'h33, 8'h80);
    run_frame(d);
    for (int k = 0; k < 8; k++) begin
      chk(q.size() > 16 + 32 * k && q[16 + 32 * k] === d[k], "data bit"); // byte before parity
    end
    chk(q.size() > 272 && q[272] === ~^d, "parity bit"); // odd parity appended
  endtask
  task automatic t_rx();
    int n;
    for (int k = 0; k < 3; k++) begin
      wr(8'h33, k == 2 ? 8'h00 : 8'h40);
      fork
        card.reply(k + 1, 8'h3C ^ k[7:0], k != 0);
        begin
          for (n = 0; n < 20 && o_rx_valid !== 1'b1; n++) @(posedge i_clock);
          chk(o_rx_data === (8'h3C ^ k[7:0]), "rx data"); // parity stripped
          chk(o_rx_parity_error === (k == 1), "rx parity flag"); // parity checked
        end
      join
      if (k == 1) rd(8'h3F, 8'h08); // parity error in status
    end
  endtask
  task automatic t_pulse();
    logic [7:0] w [4] = '{8'h03, 8'hFF, 8'hFF, 8'h03};
    int e [4] = '{8, 32, 16, 0};
    wr(8'h33, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(8'h2F, w[k]);
      i_pulse_start_select <= (k == 2);
      i_miller_en <= (k != 3);
      run_frame(8'h55);
      chk(near(prun, e[k], 2), "pulse length"); // pulse shape
    end
    // Symbol 3 framing, data all zero: only the symbols pulse, always at bit start
    wr(8'h2F, 8'h03);
    wr(8'h33, 8'h0F);
    i_miller_en <= 1'b1;
    i_pulse_start_select <= 1'b1;
    run_frame(8'h00);
    chk(near(prun, 8, 2), "symbol pulse width"); // symbol pulse
    i_miller_en <= 1'b0;
    i_pulse_start_select <= 1'b0;
  endtask
  task automatic t_symbols();
    for (int k = 0; k < 4; k++) begin
      wr(8'h33, {4'h0, 2'(k + 1), 2'(k)});
      run_frame(8'h96);
      chk(near(len, (8 + (k != 0) + (k != 3)) * 32, 12), "symbol framing"); // symbol slots
    end
  endtask
  task automatic t_guard();
    wr(8'h33, 8'h00);
    for (int k = 0; k < 9; k++) begin
      i_type_b <= (k < 8);
      wr(8'h31, {5'b11000, 3'(k == 8 ? 7 : k)});
      run_frame(8'h5A);
      chk(near(len, (8 + (k < 8 ? k : 0)) * 32, 12), "guard slots"); // stop and guard
    end
    i_type_b <= 1'b0;
  endtask
  task automatic t_burst();
    int bits [8] = '{8, 16, 32, 48, 64, 96, 128, 256};
    i_burst_en <= 1'b1;
    i_burst_level_control <= 2'b01;
    wr(8'h33, 8'h09);
    for (int k = 0; k < 8; k++) begin
      wr(8'h30, {1'b0, 3'(7 - k), 1'b0, 3'(k)});
      run_frame(8'h00);
      chk(near(blvl, bits[k] * 32, 4), "symbol zero burst"); // length and level
      chk(near(bcyc - blvl, bits[7 - k] * 32, 4), "symbol one burst"); // length and level
    end
    i_burst_en <= 1'b0;
    wr(8'h33, 8'h00);
  endtask
  task automatic t_wait();
    wr(8'h32, 8'h04);
    wr(8'h31, 8'h08);
    run_frame(8'h11);
    run_frame(8'h22);
    chk(near(len, 8320 + 256, 40), "carrier unit wait"); // held request
    wr(8'h31, 8'h60);
    run_frame(8'h33);
    run_frame(8'h44);
    chk(near(len, 16448 + 256, 40), "half bit wait"); // upper bits
    wr(8'h31, 8'h88);
    card.reply(1, 8'h77, 1'b0);
    run_frame(8'h55);
    chk(near(len, 8320 + 256, 40), "wait from rx end"); // receive end
    run_frame(8'h66);
    chk(near(len, 256, 12), "no wait after tx"); // transmit end ignored
    // Half-bit unit follows the rate: 4 units of 16 carriers at the next rate down
    i_rate_sel <= 2'h2;
    wr(8'h31, 8'h40);
    run_frame(8'h77);
    run_frame(8'h78);
    chk(near(len, 128 + 512, 16), "half bit wait at lower rate"); // unit tracks rate
    i_rate_sel <= 2'h3;
  endtask
  // ************************************
  // Main sequence and watchdog
  // ************************************
  initial begin
    i_reset = 1'b1;
    {i_write, i_read, i_miller_en, i_pulse_start_select, i_burst_en, i_type_b} = '0;
    {i_tx_start, i_tx_valid, i_addr, i_wdata, i_tx_data, i_burst_level_control} = '0;
    i_tx_last = 1'b1;
    i_rate_sel = 2'h3;
    repeat (8) @(posedge i_clock);
    i_reset <= 1'b0;
    @(posedge i_clock);
    t_regs();
    t_tx_parity();
    t_rx();
    t_pulse();
    t_symbols();
    t_guard();
    t_burst();
    t_wait();
    complete_run();
  end
  // Run needs about 90k cycles
  initial begin
    repeat (120000) @(posedge i_clock);
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
